/* File: shared/dest_y_pkg.sv */
`default_nettype none
package dest_y_pkg;

  // ********************************************************
  // Register offsets within the control aperture
  // ********************************************************
  localparam logic [13:0] OFS_DEPTH_ORIGIN  = 14'h1c0c;
  localparam logic [13:0] OFS_XY_START      = 14'h1c40;
  localparam logic [13:0] OFS_Y_LEN_ALIAS   = 14'h1c88;
  localparam logic [13:0] OFS_DEST_Y        = 14'h1c90;
  localparam logic [13:0] OFS_DEST_Y_ORIGIN = 14'h1c94;
  localparam logic [13:0] OFS_CLIP_TOP      = 14'h1c98;

  // ********************************************************
  // Field layout
  // ********************************************************
  localparam int DEST_Y_W     = 23;
  localparam int LINE_SEL_W   = 3;
  localparam int LINE_SEL_LSB = 29;
  localparam int ADDR24_W     = 24;
  localparam int LENGTH_W     = 16;
  localparam int Y_HALF_LSB   = 16;
  localparam int COORD_W      = 16;
  localparam int PITCH_W      = 12;
  localparam logic [3:0] BE_DWORD = 4'hf;

  // ********************************************************
  // Reset values (contents are undefined, zero chosen)
  // ********************************************************
  localparam logic [DEST_Y_W-1:0]   DEST_Y_RST   = 23'h000000;
  localparam logic [ADDR24_W-1:0]   ADDR24_RST   = 24'h000000;
  localparam logic [LENGTH_W-1:0]   LENGTH_RST   = 16'h0000;
  localparam logic [LINE_SEL_W-1:0] LINE_SEL_RST = 3'h0;

  typedef struct packed {
    logic        valid;
    logic [13:0] addr;
    logic [31:0] data;
    logic [3:0]  be;
  } fifo_wr_t;

  typedef struct packed {
    logic [DEST_Y_W-1:0]   dest_y;
    logic [LINE_SEL_W-1:0] line_sel;
    logic [ADDR24_W-1:0]   origin;
    logic [ADDR24_W-1:0]   clip_top;
    logic [ADDR24_W-1:0]   depth_origin;
    logic [LENGTH_W-1:0]   length;
  } setup_regs_t;

endpackage
`default_nettype wire

/* File: hdl/clip_y_window.sv */
`default_nettype none
module clip_y_window
  import dest_y_pkg::*;
(
  // Position and bounds
  input  wire logic [DEST_Y_W-1:0] y_pos_i,
  input  wire logic [ADDR24_W-1:0] top_i,
  input  wire logic [ADDR24_W-1:0] bot_i,
  // Result
  output logic                     inside_o
);

  logic [ADDR24_W-1:0] y_ext;

  // Non-negative y only; zero extension keeps the compare unsigned
  assign y_ext = {1'b0, y_pos_i};

  // Bounds are always positive, so a negative y is always out
  assign inside_o = !y_pos_i[DEST_Y_W-1] &&
                    (y_ext >= top_i) &&
                    (y_ext <= bot_i);

endmodule
`default_nettype wire

/* File: hdl/draw_dest_y_clip_regs.sv */
`default_nettype none
module draw_dest_y_clip_regs
  import dest_y_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                arst_n_i,
  // Command FIFO write port
  input  wire fifo_wr_t            cmd_i,
  // Drawing engine controls
  input  wire logic                lin_fmt_i,
  input  wire logic [PITCH_W-1:0]  pitch_i,
  input  wire logic                linearize_i,
  input  wire logic                y_load_i,
  input  wire logic [DEST_Y_W-1:0] y_load_val_i,
  input  wire logic [ADDR24_W-1:0] clip_bot_i,
  input  wire logic                pix_req_i,
  // Setup values
  output setup_regs_t              regs_o,
  // Clip results
  output logic                     inside_o,
  output logic                     pix_wr_o
);

  // ********************************************************
  // Write decode
  // ********************************************************
  logic        wr_ok;
  logic [31:0] wd;
  assign wr_ok = cmd_i.valid && (cmd_i.be == BE_DWORD);
  assign wd    = cmd_i.data;

  // ********************************************************
  // Setup registers
  // ********************************************************
  localparam int PROD_W = COORD_W + PITCH_W + 1;

  setup_regs_t              r_q;
  setup_regs_t              r_d;
  logic [DEST_Y_W-1:0]      lin_y;
  logic [DEST_Y_W-1:0]      prod;
  logic [DEST_Y_W-1:0]      y_half_ext;
  logic signed [PROD_W-1:0] prod_w;

  // Full-width product first: a narrow multiply would lose the top bits
  assign prod_w = $signed(r_q.dest_y[COORD_W-1:0]) *
                  $signed({1'b0, pitch_i});
  // Linear addresses wrap at the width of the y field
  assign prod   = prod_w[DEST_Y_W-1:0];
  assign lin_y  = prod + DEST_Y_W'(r_q.origin);

  // Upper half of a write, sign extended into the y field
  assign y_half_ext = DEST_Y_W'($signed(wd[Y_HALF_LSB +: COORD_W]));

  always_comb begin
    r_d = r_q;
    // Software writes win over engine updates in the same cycle
    if (wr_ok) begin
      case (cmd_i.addr)
        OFS_DEST_Y: begin
          r_d.dest_y   = wd[DEST_Y_W-1:0];
          r_d.line_sel = wd[LINE_SEL_LSB +: LINE_SEL_W];
        end
        OFS_Y_LEN_ALIAS: begin
          r_d.length = wd[LENGTH_W-1:0];
          r_d.dest_y = y_half_ext;
        end
        OFS_XY_START: begin
          r_d.dest_y   = y_half_ext;
          r_d.line_sel = LINE_SEL_RST;
        end
        OFS_DEST_Y_ORIGIN: r_d.origin = wd[ADDR24_W-1:0];
        OFS_CLIP_TOP:      r_d.clip_top = wd[ADDR24_W-1:0];
        OFS_DEPTH_ORIGIN: begin
          // Upper bits are reserved and dropped here
          r_d.depth_origin = wd[ADDR24_W-1:0];
        end
        default: ;
      endcase
    end else if (linearize_i && !lin_fmt_i) begin
      r_d.dest_y   = lin_y;
      r_d.line_sel = r_q.dest_y[LINE_SEL_W-1:0];
    end else if (y_load_i) begin
      r_d.dest_y = y_load_val_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_q <= '{dest_y: DEST_Y_RST, line_sel: LINE_SEL_RST,
                origin: ADDR24_RST, clip_top: ADDR24_RST,
                depth_origin: ADDR24_RST, length: LENGTH_RST};
    end else begin
      r_q <= r_d;
    end
  end

  assign regs_o = r_q;

  // ********************************************************
  // Clip window
  // ********************************************************
  logic in_now;
  logic inside_q;
  logic inside_d;
  logic wr_q;
  logic wr_d;

  // No enable input exists: the compare always gates writes
  clip_y_window u_clip (
    .y_pos_i  (r_q.dest_y),
    .top_i    (r_q.clip_top),
    .bot_i    (clip_bot_i),
    .inside_o (in_now)
  );

  always_comb begin
    inside_d = in_now;
    wr_d     = pix_req_i && in_now;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      inside_q <= 1'b0;
      wr_q     <= 1'b0;
    end else begin
      inside_q <= inside_d;
      wr_q     <= wr_d;
    end
  end

  assign inside_o = inside_q;
  assign pix_wr_o = wr_q;

  // ********************************************************
  // Assertions
  // ********************************************************
  // Independent model of the linear address, built from regs_o and pitch_i
  logic signed [PROD_W-1:0] exp_prod;
  assign exp_prod = $signed(regs_o.dest_y[COORD_W-1:0]) *
                    $signed({1'b0, pitch_i}) +
                    $signed({1'b0, regs_o.origin});

  sequence s_alias_wr;
    cmd_i.valid && cmd_i.be == BE_DWORD && cmd_i.addr == OFS_Y_LEN_ALIAS;
  endsequence

  sequence s_dest_wr;
    cmd_i.valid && cmd_i.be == BE_DWORD && cmd_i.addr == OFS_DEST_Y;
  endsequence

  sequence s_lin;
    !(cmd_i.valid && cmd_i.be == BE_DWORD) && linearize_i && !lin_fmt_i;
  endsequence

  sequence s_lin_held;
    !(cmd_i.valid && cmd_i.be == BE_DWORD) && linearize_i && lin_fmt_i &&
      !y_load_i;
  endsequence

  sequence s_eng_load;
    !(cmd_i.valid && cmd_i.be == BE_DWORD) && !linearize_i && y_load_i;
  endsequence

  AST_ALIAS_Y: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_alias_wr |=> regs_o.dest_y ==
      DEST_Y_W'($signed($past(cmd_i.data[Y_HALF_LSB +: COORD_W]))))
    else $error("alias y not sign extended");

  AST_ALIAS_LEN: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_alias_wr |=> regs_o.length == $past(cmd_i.data[LENGTH_W-1:0]) &&
      $stable(regs_o.origin) && $stable(regs_o.line_sel))
    else $error("alias length wrong");

  AST_DEST_WR: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_dest_wr |=> regs_o.dest_y == $past(cmd_i.data[DEST_Y_W-1:0]) &&
      regs_o.line_sel == $past(cmd_i.data[LINE_SEL_LSB +: LINE_SEL_W]))
    else $error("destination y write wrong");

  AST_LIN_SEL: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_lin |=> regs_o.line_sel == $past(regs_o.dest_y[LINE_SEL_W-1:0]))
    else $error("selected line not copied");

  AST_LIN_Y: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_lin |=> regs_o.dest_y == $past(exp_prod[DEST_Y_W-1:0]))
    else $error("y not linearized");

  AST_LIN_HOLD: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_lin_held |=> $stable(regs_o.dest_y) && $stable(regs_o.line_sel))
    else $error("linear y changed by linearize");

  AST_ENG_LOAD: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_eng_load |=> regs_o.dest_y == $past(y_load_val_i))
    else $error("engine y load lost");

  AST_NEG_OUT: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    regs_o.dest_y[DEST_Y_W-1] |=> !inside_o && !pix_wr_o)
    else $error("negative y inside");

  AST_TOP: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    ({1'b0, regs_o.dest_y} < regs_o.clip_top) |=> !inside_o)
    else $error("above top bound inside");

  AST_BOT: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    ({1'b0, regs_o.dest_y} > clip_bot_i) |=> !inside_o)
    else $error("below bottom bound inside");

  AST_PIX_ON: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    pix_req_i && !regs_o.dest_y[DEST_Y_W-1] &&
      {1'b0, regs_o.dest_y} >= regs_o.clip_top &&
      {1'b0, regs_o.dest_y} <= clip_bot_i |=> pix_wr_o && inside_o)
    else $error("write inside window dropped");

  AST_WR_SUPP: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    pix_wr_o |-> inside_o && $past(pix_req_i))
    else $error("write outside window");

  AST_PART_IGN: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (cmd_i.valid && cmd_i.be != BE_DWORD && !linearize_i && !y_load_i)
      |=> $stable(regs_o))
    else $error("partial write accepted");

  AST_DEPTH_RSV: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (cmd_i.valid && cmd_i.be == BE_DWORD && cmd_i.addr == OFS_DEPTH_ORIGIN)
      |=> regs_o.depth_origin == $past(cmd_i.data[ADDR24_W-1:0]))
    else $error("depth origin wrong");

endmodule
`default_nettype wire

/* File: verification/draw_dest_y_clip_regs_test.sv */
`default_nettype none
module draw_dest_y_clip_regs_test import dest_y_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************
  // Stimulus and observed signals
  // ****************************************************
  logic                clk_sys_i = 1'b0;
  logic                arst_n_i  = 1'b0;
  fifo_wr_t            cmd_i;
  logic                lin_fmt_i, linearize_i, y_load_i, pix_req_i;
  logic [PITCH_W-1:0]  pitch_i;
  logic [DEST_Y_W-1:0] y_load_val_i;
  logic [ADDR24_W-1:0] clip_bot_i;
  setup_regs_t         regs_o;
  logic                inside_o, pix_wr_o;
  int                  bad_count  = 0;
  int                  n_compared = 0;
  logic [22:0] cy [6] = '{23'h180, 23'h1f, 23'h20, 23'h200, 23'h201,
                          23'h7fffff};
  logic        cx [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  always #5 clk_sys_i = ~clk_sys_i;

  draw_dest_y_clip_regs uut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .cmd_i(cmd_i),
    .lin_fmt_i(lin_fmt_i), .pitch_i(pitch_i), .linearize_i(linearize_i),
    .y_load_i(y_load_i), .y_load_val_i(y_load_val_i),
    .clip_bot_i(clip_bot_i), .pix_req_i(pix_req_i), .regs_o(regs_o),
    .inside_o(inside_o), .pix_wr_o(pix_wr_o));

  // ****************************************************
  // Access tasks
  // ****************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // No acknowledge exists, so the write is taken at the one rising edge
  task automatic wr(input logic [13:0] a, input logic [31:0] d,
                    input logic [3:0] be = BE_DWORD);
    @(negedge clk_sys_i);
    cmd_i = '{valid: 1'b1, addr: a, data: d, be: be};
    @(negedge clk_sys_i);
    cmd_i.valid = 1'b0;
  endtask

  task automatic pulse_lin();
    @(negedge clk_sys_i);
    linearize_i = 1'b1;
    @(negedge clk_sys_i);
    linearize_i = 1'b0;
  endtask

  task automatic load_y(input logic [22:0] v);
    @(negedge clk_sys_i);
    y_load_i     = 1'b1;
    y_load_val_i = v;
    @(negedge clk_sys_i);
    y_load_i = 1'b0;
    // Inside flag lags the register by one more cycle
    repeat (2) @(negedge clk_sys_i);
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************
  // Tests
  // ****************************************************
  initial begin
    #100000;
    bad_count++;
    final_report();
  end

  initial begin
    cmd_i = '0;
    {lin_fmt_i, linearize_i, y_load_i, pix_req_i} = 4'h0;
    pitch_i = 12'h040;
    y_load_val_i = 23'h0;
    clip_bot_i = 24'h000200;
    repeat (10) @(negedge clk_sys_i);
    chk(32'(regs_o.dest_y), 32'h0);
    arst_n_i = 1'b1;
    $display("test reset done");
    wr(OFS_DEST_Y, 32'hbf800123);
    chk(32'(regs_o.dest_y), 32'h000123);
    chk(32'(regs_o.line_sel), 32'h5);
    wr(OFS_DEST_Y, 32'h00000777, 4'h7);
    wr(14'h1c9c & 14'h1c00, 32'h00000777);
    chk(32'(regs_o.dest_y), 32'h000123);
    wr(OFS_Y_LEN_ALIAS, 32'hffff0010);
    chk(32'(regs_o.dest_y), 32'h7fffff);
    chk(32'(regs_o.length), 32'h0010);
    chk(32'(regs_o.line_sel), 32'h5);
    wr(OFS_DEST_Y_ORIGIN, 32'hff000040);
    chk(32'(regs_o.origin), 32'h000040);
    wr(OFS_CLIP_TOP, 32'hee000020);
    chk(32'(regs_o.clip_top), 32'h000020);
    wr(OFS_DEPTH_ORIGIN, 32'hab200000);
    chk(32'(regs_o.depth_origin), 32'h200000);
    $display("test register writes done");
    wr(OFS_XY_START, 32'h00050007);
    chk(32'(regs_o.dest_y), 32'h000005);
    chk(32'(regs_o.line_sel), 32'h0);
    pulse_lin();
    chk(32'(regs_o.dest_y), 32'h000180);
    chk(32'(regs_o.line_sel), 32'h5);
    wr(OFS_XY_START, 32'hfffe0000);
    pulse_lin();
    chk(32'(regs_o.dest_y), 32'h7fffc0);
    chk(32'(regs_o.line_sel), 32'h6);
    lin_fmt_i = 1'b1;
    pulse_lin();
    chk(32'(regs_o.dest_y), 32'h7fffc0);
    $display("test linearize done");
    pix_req_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      load_y(cy[i]);
      chk(32'(inside_o), 32'(cx[i]));
      chk(32'(pix_wr_o), 32'(cx[i]));
    end
    pix_req_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk(32'(pix_wr_o), 32'h0);
    $display("test clipping done");
    final_report();
  end
endmodule
`default_nettype wire
